// *** dv/mbw_master_model.sv ***
// Bus master stand-in: decoded requests and message events
`timescale 1ns/10ps
module mbw_master_model (
	// Clock
	input wire logic clk,
	// Request
	output logic req_valid,
	output logic [7:0] req_func,
	output logic [15:0] req_addr,
	output logic [15:0] req_wdata,
	// Answer
	input wire logic rsp_valid,
	input wire logic [15:0] rsp_data,
	input wire logic [7:0] rsp_exc,
	// Message events
	output logic msg_ok,
	output logic tx_done
);
	initial
	begin
		req_valid = 1'b0;
		req_func = 8'h00;
		req_addr = 16'h0000;
		req_wdata = 16'h0000;
		msg_ok = 1'b0;
		tx_done = 1'b0;
	end
	task automatic access(input logic [7:0] f, input logic [15:0] a, input logic [15:0] w,
		output logic [15:0] d, output logic [7:0] e, output logic ok);
		ok = 1'b0;
		@(negedge clk);
		req_valid = 1'b1;
		req_func = f;
		req_addr = a;
		req_wdata = w;
		@(negedge clk);
		req_valid = 1'b0;
		// Released lines flip so a stale value is never trusted
		req_func = ~f;
		req_addr = ~a;
		req_wdata = ~w;
		for (int i = 0; i < 4 && !ok; i++)
		begin
			if (rsp_valid === 1'b1)
			begin
				d = rsp_data;
				e = rsp_exc;
				ok = 1'b1;
			end
			else
				@(negedge clk);
		end
	endtask
	task automatic pulse_msg();
		@(negedge clk);
		msg_ok = 1'b1;
		@(negedge clk);
		msg_ok = 1'b0;
	endtask
	task automatic pulse_done();
		@(negedge clk);
		tx_done = 1'b1;
		@(negedge clk);
		tx_done = 1'b0;
	endtask
endmodule

// *** dv/mbw_regbank_properties.sv ***
// Port-level assertions for the Modbus register bank
`timescale 1ns/10ps
module mbw_regbank_properties (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Request and answer
	input wire logic req_valid,
	input wire logic [7:0] req_func,
	input wire logic [15:0] req_addr,
	input wire logic [15:0] req_wdata,
	input wire logic rsp_valid,
	input wire logic [7:0] rsp_exc,
	// Reply sequence
	input wire logic msg_ok,
	input wire logic tx_done,
	input wire logic tx_indicator,
	input wire logic tx_start,
	// Inputs and outputs
	input wire logic din_one,
	input wire logic din_two,
	input wire logic input_one_indicator,
	input wire logic input_two_indicator,
	input wire logic [15:0] dig_out
);
	import mbw_pkg::*;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	////////////////////////////////////////////////////////////////////////
	property p_rsp_follow;
		req_valid |=> rsp_valid;
	endproperty
	a_rsp_follow: assert property (p_rsp_follow)
		else $error("answer missing after request");
	property p_rsp_quiet;
		!req_valid |=> !rsp_valid;
	endproperty
	a_rsp_quiet: assert property (p_rsp_quiet)
		else $error("answer without request");
	property p_bad_func;
		req_valid && req_func == 8'h07 |=> rsp_exc == EXC_FUNC;
	endproperty
	a_bad_func: assert property (p_bad_func)
		else $error("unknown function not refused");
	property p_bad_addr;
		req_valid && req_func == FC_RD_INPUT_REG && req_addr == 16'h0010 |=> rsp_exc == EXC_ADDR;
	endproperty
	a_bad_addr: assert property (p_bad_addr)
		else $error("unmapped input register not refused");
	property p_out_write;
		req_valid && req_func == FC_WR_HOLD_REG && req_addr == REG_OUTPUTS
			|=> dig_out == $past(req_wdata);
	endproperty
	a_out_write: assert property (p_out_write)
		else $error("output word not written");
	property p_coil_on;
		req_valid && req_func == FC_WR_COIL && req_addr == 16'h0003 && req_wdata == COIL_ON
			|=> dig_out[3];
	endproperty
	a_coil_on: assert property (p_coil_on)
		else $error("coil not set");
	////////////////////////////////////////////////////////////////////////
	property p_tx_start;
		msg_ok && !tx_indicator |=> tx_indicator;
	endproperty
	a_tx_start: assert property (p_tx_start)
		else $error("transmit lamp late");
	property p_tx_quiet;
		!tx_indicator && !msg_ok |=> !tx_indicator;
	endproperty
	a_tx_quiet: assert property (p_tx_quiet)
		else $error("transmit lamp without message");
	property p_tx_hold;
		tx_indicator && !tx_done |=> tx_indicator;
	endproperty
	a_tx_hold: assert property (p_tx_hold)
		else $error("transmit lamp dropped early");
	property p_tx_go;
		tx_start |-> msg_ok || tx_indicator;
	endproperty
	a_tx_go: assert property (p_tx_go)
		else $error("send without message");
	// Filter needs several high samples before the lamp may light
	property p_ind_one;
		$rose(input_one_indicator) |-> $past(din_one, 3) && $past(din_one, 4);
	endproperty
	a_ind_one: assert property (p_ind_one)
		else $error("input one lamp without high input");
	property p_ind_two;
		$rose(input_two_indicator) |-> $past(din_two, 3) && $past(din_two, 4);
	endproperty
	a_ind_two: assert property (p_ind_two)
		else $error("input two lamp without high input");
	c_write: cover property (req_valid && req_func == FC_WR_HOLD_REG);
	c_reply: cover property (tx_indicator ##1 !tx_indicator);
	c_lamp: cover property ($rose(input_one_indicator));
endmodule

bind mbw_regbank mbw_regbank_properties u_props (
	.clk(clk), .reset(reset), .req_valid(req_valid), .req_func(req_func),
	.req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
	.rsp_exc(rsp_exc), .msg_ok(msg_ok), .tx_done(tx_done),
	.tx_indicator(tx_indicator), .tx_start(tx_start), .din_one(din_one), .din_two(din_two),
	.input_one_indicator(input_one_indicator),
	.input_two_indicator(input_two_indicator), .dig_out(dig_out)
);

// *** dv/tb_top.sv ***
// Self-checking bench for the Modbus register bank
`timescale 1ns/10ps
module tb_top;
	import mbw_pkg::*;
	localparam int MS = 20;
	logic clk, reset, din_one, din_two, ok;
	logic [15:0] rd;
	logic [7:0] ex;
	int miscompares, total_checks;
	wire logic req_valid, rsp_valid, msg_ok, tx_done;
	wire logic [7:0] req_func, rsp_exc;
	wire logic [15:0] req_addr, req_wdata, rsp_data;
	logic [7:0] slave_address;
	logic [31:0] line_speed_bps;
	mbw_parity_t parity_mode;
	logic two_stop_bits, seven_data_bits, ascii_framing, ao_4_20_mode;
	logic [15:0] dig_out, ao_current_ua, ao_voltage_mv;
	logic input_one_indicator, input_two_indicator, tx_indicator;
	////////////////////////////////////////////////////////////////////////
	mbw_regbank #(.MS_CYC(MS), .FILTER(4)) u_dut (
		.clk(clk), .reset(reset), .req_valid(req_valid), .req_func(req_func),
		.req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
		.rsp_data(rsp_data), .rsp_exc(rsp_exc), .msg_ok(msg_ok), .tx_done(tx_done),
		.tx_start(), .slave_address(slave_address), .line_speed_bps(line_speed_bps),
		.parity_mode(parity_mode), .two_stop_bits(two_stop_bits),
		.seven_data_bits(seven_data_bits), .ascii_framing(ascii_framing),
		.din_one(din_one), .din_two(din_two), .dig_out(dig_out),
		.ao_4_20_mode(ao_4_20_mode), .ao_current_ua(ao_current_ua),
		.ao_voltage_mv(ao_voltage_mv), .input_one_indicator(input_one_indicator),
		.input_two_indicator(input_two_indicator), .tx_indicator(tx_indicator)
	);
	mbw_master_model u_master (
		.clk(clk), .req_valid(req_valid), .req_func(req_func), .req_addr(req_addr),
		.req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
		.rsp_exc(rsp_exc), .msg_ok(msg_ok), .tx_done(tx_done)
	);
	always #2.5 clk = ~clk;
	////////////////////////////////////////////////////////////////////////
	task automatic finish_test();
		if (miscompares == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic acc(input logic [7:0] f, input logic [15:0] a, input logic [15:0] w);
		u_master.access(f, a, w, rd, ex, ok);
		if (ok !== 1'b1)
		begin
			miscompares++;
			finish_test();
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [15:0] w);
		acc(FC_WR_HOLD_REG, a, w);
		chk(ex, EXC_NONE);
	endtask
	task automatic rdh(input logic [15:0] a, input logic [15:0] exp);
		acc(FC_RD_HOLD_REG, a, 16'h0000);
		chk(rd, exp);
	endtask
	task automatic wait_n(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic wait_low();
		for (int i = 0; i < 4 && tx_indicator !== 1'b0; i++)
			@(negedge clk);
		chk(tx_indicator, 1'h0);
		if (tx_indicator !== 1'b0)
			finish_test();
	endtask
	// Scaled pulse: filter shortened, so widths shrink in proportion
	task automatic pulse(input logic two);
		din_one = ~two;
		din_two = two;
		wait_n(12);
		chk(two ? input_two_indicator : input_one_indicator, 1'h1);
		din_one = 1'b0;
		din_two = 1'b0;
		wait_n(20);
		chk(two ? input_two_indicator : input_one_indicator, 1'h0);
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic t_defaults();
		chk(line_speed_bps, 32'h0000_4B00);
		chk(32'(parity_mode), 32'h0000_0000);
		chk({two_stop_bits, seven_data_bits, ascii_framing}, 3'h0);
		chk(slave_address, 8'h01);
		chk(dig_out, 16'h0000);
		rdh(REG_LINE_SPEED, 16'h0003);
		rdh(REG_FRAME_BITS, 16'h0108);
		rdh(REG_REPLY_WAIT, 16'h0000);
		rdh(REG_FRAMING, 16'h0000);
		rdh(REG_WATCHDOG, 16'h0000);
	endtask
	task automatic t_serial();
		logic [31:0] rate [7] = '{32'h0000_0960, 32'h0000_12C0, 32'h0000_2580,
			32'h0000_4B00, 32'h0000_9600, 32'h0000_E100, 32'h0001_C200};
		for (int i = 0; i < 7; i++)
		begin
			wr(REG_LINE_SPEED, 16'(i));
			chk(line_speed_bps, rate[i]);
		end
		wr(REG_LINE_SPEED, 16'h0064);
		chk(line_speed_bps, 32'h0000_03E8);
		wr(REG_LINE_SPEED, 16'h0003);
		for (int i = 0; i < 5; i++)
		begin
			wr(REG_PARITY, 16'(i));
			chk(32'(parity_mode), 32'(i));
		end
		wr(REG_PARITY, 16'h0000);
		wr(REG_FRAME_BITS, 16'h0207);
		chk({two_stop_bits, seven_data_bits}, 2'h3);
		wr(REG_FRAME_BITS, 16'h0108);
		chk({two_stop_bits, seven_data_bits}, 2'h0);
		wr(REG_FRAMING, 16'h0001);
		chk(ascii_framing, 1'h1);
		wr(REG_FRAMING, 16'h0000);
		chk(ascii_framing, 1'h0);
	endtask
	task automatic t_spaces();
		acc(FC_WR_COIL, 16'h0003, COIL_ON);
		chk(dig_out, 16'h0008);
		acc(FC_WR_COILS, 16'h0004, 16'h0001);
		chk(dig_out, 16'h0018);
		acc(FC_RD_COILS, 16'h0004, 16'h0000);
		chk(rd, 16'h0001);
		acc(FC_WR_COIL, 16'h0003, 16'h1234);
		chk({ex, dig_out}, {EXC_VALUE, 16'h0018});
		acc(FC_RD_DISCRETE, 16'h0000, 16'h0000);
		chk(rd, 16'h0000);
		acc(FC_RD_INPUT_REG, 16'h0001, 16'h0000);
		chk(rd, 16'h0001);
		acc(FC_RD_INPUT_REG, 16'h0010, 16'h0000);
		chk(ex, EXC_ADDR);
		acc(8'h07, 16'h0000, 16'h0000);
		chk(ex, EXC_FUNC);
		acc(FC_WR_HOLD_REGS, REG_OUTPUTS, 16'h0000);
		chk(dig_out, 16'h0000);
	endtask
	task automatic t_analog();
		wr(REG_AO_MODE, 16'h0001);
		wr(REG_AO_CURRENT, 16'h000A);
		wait_n(2);
		chk({ao_4_20_mode, ao_current_ua}, 17'h1_1040);
		wr(REG_AO_MODE, 16'h0000);
		wait_n(2);
		chk(ao_current_ua, 16'h000A);
	endtask
	task automatic t_counter();
		repeat (3) pulse(1'b0);
		rdh(REG_CNT1_LO, 16'h0003);
		pulse(1'b1);
		rdh(REG_CNT2_LO, 16'h0001);
		wr(REG_CNT1_LO, 16'hFFFF);
		wr(REG_CNT1_HI, 16'hFFFF);
		pulse(1'b0);
		rdh(REG_CNT1_LO, 16'h0000);
		rdh(REG_CNT1_HI, 16'h0000);
	endtask
	task automatic t_reply();
		wr(REG_REPLY_WAIT, 16'h0001);
		u_master.pulse_msg();
		wait_n(1);
		chk(tx_indicator, 1'h1);
		u_master.pulse_done();
		wait_n(3);
		chk(tx_indicator, 1'h1);
		wait_n(30);
		u_master.pulse_done();
		wait_low();
		wr(REG_REPLY_WAIT, 16'h0000);
	endtask
	task automatic t_watchdog();
		wr(REG_DEFAULT_OUT, 16'h00A5);
		wr(REG_AO_VOLTAGE, 16'h1234);
		wr(REG_OUTPUTS, 16'h0F0F);
		wr(REG_WATCHDOG, 16'h0002);
		u_master.pulse_msg();
		wait_n(30);
		chk(dig_out, 16'h0F0F);
		u_master.pulse_msg();
		wait_n(30);
		chk(dig_out, 16'h0F0F);
		wait_n(15);
		chk({dig_out, ao_voltage_mv}, {16'h00A5, 16'h0000});
		wr(REG_WATCHDOG, 16'h0000);
		wr(REG_OUTPUTS, 16'h0055);
		u_master.pulse_msg();
		wait_n(100);
		chk(dig_out, 16'h0055);
		u_master.pulse_done();
		wait_low();
	endtask
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		clk = 1'b0;
		reset = 1'b1;
		din_one = 1'b0;
		din_two = 1'b0;
		miscompares = 0;
		total_checks = 0;
		wait_n(4);
		reset = 1'b0;
		t_defaults();
		t_serial();
		t_spaces();
		t_analog();
		t_counter();
		t_reply();
		t_watchdog();
		finish_test();
	end
endmodule

// *** rtl/mbw_cnt_if.sv ***
// Carrier between the register bank and one pulse counter
`timescale 1ns/10ps
interface mbw_cnt_if;
	logic wr_lo;
	logic wr_hi;
	logic [15:0] wdata;
	logic [31:0] count;
	logic level;

	modport ctl (output wr_lo, output wr_hi, output wdata, input count, input level);
	modport cnt (input wr_lo, input wr_hi, input wdata, output count, output level);
endinterface

// *** rtl/mbw_ms_timer.sv ***
// Millisecond down-timer, restarted by a start pulse
`timescale 1ns/10ps
module mbw_ms_timer #(
	parameter int MS_CYC = 200000
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Control
	input wire logic start,
	input wire logic stop,
	input wire logic [15:0] load,
	// Status
	output logic running,
	output logic expire
);
	import mbw_pkg::*;

	localparam int PW = $clog2(MS_CYC + 1);

	logic run_q, run_d;
	logic [15:0] rem_q, rem_d;
	logic [PW-1:0] pre_q, pre_d;
	logic exp_q, exp_d;

	always_comb
	begin
		run_d = run_q;
		rem_d = rem_q;
		pre_d = pre_q;
		exp_d = 1'b0;
		if (stop)
			run_d = 1'b0;
		else if (start)
		begin
			// Prescaler cleared so the first millisecond is a full one
			run_d = (load != 16'h0000);
			rem_d = load;
			pre_d = '0;
		end
		else if (run_q)
		begin
			pre_d = pre_q + PW'(1);
			if (pre_q == PW'(MS_CYC - 1))
			begin
				pre_d = '0;
				rem_d = rem_q - 16'h0001;
				if (rem_q == 16'h0001)
				begin
					run_d = 1'b0;
					exp_d = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			run_q <= 1'b0;
			rem_q <= 16'h0000;
			pre_q <= '0;
			exp_q <= 1'b0;
		end
		else
		begin
			run_q <= run_d;
			rem_q <= rem_d;
			pre_q <= pre_d;
			exp_q <= exp_d;
		end
	end

	assign running = run_q;
	assign expire = exp_q;
endmodule

// *** rtl/mbw_pkg.sv ***
// Constants, types and decode helpers for the Modbus I/O register bank
package mbw_pkg;

	////////////////////////////////////////////////////////////////////////
	// Clock and time
	localparam int CLK_PERIOD_NS = 5;
	localparam int MS_NS = 1_000_000;
	localparam int MS_CYCLES = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Input filter, well below the shortest legal pulse of 500 us
	localparam int FILTER_US = 100;
	localparam int FILTER_CYCLES = (FILTER_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	////////////////////////////////////////////////////////////////////////
	// Function codes
	localparam logic [7:0] FC_RD_COILS = 8'h01;
	localparam logic [7:0] FC_RD_DISCRETE = 8'h02;
	localparam logic [7:0] FC_RD_INPUT_REG = 8'h03;
	localparam logic [7:0] FC_RD_HOLD_REG = 8'h04;
	localparam logic [7:0] FC_WR_COIL = 8'h05;
	localparam logic [7:0] FC_WR_HOLD_REG = 8'h06;
	localparam logic [7:0] FC_WR_COILS = 8'h0F;
	localparam logic [7:0] FC_WR_HOLD_REGS = 8'h10;

	////////////////////////////////////////////////////////////////////////
	// Exception codes in the answer
	localparam logic [7:0] EXC_NONE = 8'h00;
	localparam logic [7:0] EXC_FUNC = 8'h01;
	localparam logic [7:0] EXC_ADDR = 8'h02;
	localparam logic [7:0] EXC_VALUE = 8'h03;

	////////////////////////////////////////////////////////////////////////
	// Register offsets (protocol address, zero based)
	localparam logic [15:0] REG_VERSION = 16'h0000;
	localparam logic [15:0] REG_SLAVE_ADDR = 16'h0001;
	localparam logic [15:0] REG_LINE_SPEED = 16'h0002;
	localparam logic [15:0] REG_FRAME_BITS = 16'h0003;
	localparam logic [15:0] REG_PARITY = 16'h0004;
	localparam logic [15:0] REG_REPLY_WAIT = 16'h0005;
	localparam logic [15:0] REG_FRAMING = 16'h0006;
	localparam logic [15:0] REG_WATCHDOG = 16'h0008;
	localparam logic [15:0] REG_DEFAULT_OUT = 16'h000C;
	localparam logic [15:0] REG_INPUTS = 16'h0032;
	localparam logic [15:0] REG_OUTPUTS = 16'h0033;
	localparam logic [15:0] REG_AO_CURRENT = 16'h0034;
	localparam logic [15:0] REG_AO_VOLTAGE = 16'h0035;
	localparam logic [15:0] REG_CNT1_LO = 16'h0036;
	localparam logic [15:0] REG_CNT1_HI = 16'h0037;
	localparam logic [15:0] REG_CNT2_LO = 16'h0038;
	localparam logic [15:0] REG_CNT2_HI = 16'h0039;
	localparam logic [15:0] REG_AO_MODE = 16'h0040;
	localparam logic [15:0] COIL_COUNT = 16'h0010;
	localparam logic [15:0] INPUT_COUNT = 16'h0002;

	////////////////////////////////////////////////////////////////////////
	// Reset values and fixed words
	localparam logic [15:0] RST_LINE_SPEED = 16'h0003;
	localparam logic [15:0] RST_FRAME_BITS = 16'h0108;
	localparam logic [15:0] RST_ZERO = 16'h0000;
	localparam logic [15:0] SLAVE_ADDR_DEFAULT = 16'h0001;
	// Arbitrary identification word
	localparam logic [15:0] VERSION_WORD = 16'h00A5;
	localparam logic [15:0] COIL_ON = 16'hFF00;
	localparam logic [7:0] STOP_TWO = 8'h02;
	localparam logic [7:0] DATA_SEVEN = 8'h07;
	localparam logic [15:0] LIVE_ZERO_UA = 16'h0FA0;
	localparam logic [15:0] STEP_UA = 16'h0010;

	typedef enum logic [2:0] {PAR_NONE, PAR_ODD, PAR_EVEN, PAR_ZERO, PAR_ONE} mbw_parity_t;

	function automatic logic [31:0] mbw_baud(input logic [15:0] code);
		unique case (code)
			16'h0000: mbw_baud = 32'h0000_0960;
			16'h0001: mbw_baud = 32'h0000_12C0;
			16'h0002: mbw_baud = 32'h0000_2580;
			16'h0003: mbw_baud = 32'h0000_4B00;
			16'h0004: mbw_baud = 32'h0000_9600;
			16'h0005: mbw_baud = 32'h0000_E100;
			16'h0006: mbw_baud = 32'h0001_C200;
			default: mbw_baud = 32'({16'h0000, code} * 32'h0000_000A);
		endcase
	endfunction

endpackage

// *** rtl/mbw_pulse_counter.sv ***
// Filtered input with a 32-bit rising-edge counter
`timescale 1ns/10ps
module mbw_pulse_counter #(
	parameter int FILTER = 20000
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Raw input
	input wire logic din,
	// Register side
	mbw_cnt_if.cnt bus
);
	import mbw_pkg::*;

	localparam int FW = $clog2(FILTER + 1);

	logic din_q, din_d;
	logic level_q, level_d;
	logic [FW-1:0] stable_q, stable_d;
	logic [31:0] count_q, count_d;

	always_comb
	begin
		din_d = din;
		level_d = level_q;
		stable_d = '0;
		count_d = count_q;
		// Level flips only after the new value has held for the whole filter span
		if (din_q != level_q)
		begin
			stable_d = stable_q + FW'(1);
			if (stable_q == FW'(FILTER - 1))
			begin
				level_d = din_q;
				stable_d = '0;
			end
		end
		if (level_d && !level_q)
			count_d = count_q + 32'h0000_0001;
		// Software load of either half wins over a coincident edge
		if (bus.wr_lo)
			count_d[15:0] = bus.wdata;
		if (bus.wr_hi)
			count_d[31:16] = bus.wdata;
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			din_q <= 1'b0;
			level_q <= 1'b0;
			stable_q <= '0;
			count_q <= 32'h0000_0000;
		end
		else
		begin
			din_q <= din_d;
			level_q <= level_d;
			stable_q <= stable_d;
			count_q <= count_d;
		end
	end

	assign bus.count = count_q;
	assign bus.level = level_q;
endmodule

// *** rtl/mbw_regbank.sv ***
// Modbus register bank with watchdog, reply delay, counters and indicators
//
// Function
// - Coil space at 00001, codes 1, 5, 15
// - Read-only discrete inputs at 10001, code 2
// - Input registers at 30001, read by code 3
// - Holding registers at 40001, codes 4, 6, 16
// - All registers 16 bits, RTU or ASCII
// - Defaults: address 1, 19200, 8N1, RTU
// - Baud codes 0-6 tabled, others times ten
// - Parity: none, odd, even, zero, one
// - Offset 0x03 stop bits: one or two
// - Offset 0x03 data bits: seven or eight
// - Wait reply delay milliseconds before replying
// - Framing register: 0 RTU, 1 ASCII
// - Watchdog timeout forces outputs to defaults
// - Watchdog resets to zero; zero disables it
// - Current value: per-mille at 4-20, microamps at 0-20
// - Transmit indicator lit while answering good packet
// - Input indicator lit while input high
// - Default output state applied at power-on, timeout
`timescale 1ns/10ps
module mbw_regbank #(
	parameter int MS_CYC = mbw_pkg::MS_CYCLES,
	parameter int FILTER = mbw_pkg::FILTER_CYCLES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Decoded request from the frame engine
	input wire logic req_valid,
	input wire logic [7:0] req_func,
	input wire logic [15:0] req_addr,
	input wire logic [15:0] req_wdata,
	// Answer
	output logic rsp_valid,
	output logic [15:0] rsp_data,
	output logic [7:0] rsp_exc,
	// Message and transmit handshake
	input wire logic msg_ok,
	input wire logic tx_done,
	output logic tx_start,
	// Serial line setup
	output logic [7:0] slave_address,
	output logic [31:0] line_speed_bps,
	output mbw_pkg::mbw_parity_t parity_mode,
	output logic two_stop_bits,
	output logic seven_data_bits,
	output logic ascii_framing,
	// Digital inputs
	input wire logic din_one,
	input wire logic din_two,
	// Outputs
	output logic [15:0] dig_out,
	output logic ao_4_20_mode,
	output logic [15:0] ao_current_ua,
	output logic [15:0] ao_voltage_mv,
	// Indicators
	output logic input_one_indicator,
	output logic input_two_indicator,
	output logic tx_indicator
);
	import mbw_pkg::*;

	typedef enum logic [1:0] {TX_IDLE, TX_WAIT, TX_SEND} mbw_tx_t;

	////////////////////////////////////////////////////////////////////////
	// State
	logic [15:0] speed_q, speed_d;
	logic [15:0] frame_q, frame_d;
	logic [15:0] parity_q, parity_d;
	logic [15:0] wait_q, wait_d;
	logic [15:0] framing_q, framing_d;
	logic [15:0] wdog_q, wdog_d;
	logic [15:0] dflt_q, dflt_d;
	logic [15:0] outs_q, outs_d;
	logic [15:0] aoc_q, aoc_d;
	logic [15:0] aov_q, aov_d;
	logic [15:0] aom_q, aom_d;
	logic rsp_valid_q, rsp_valid_d;
	logic [15:0] rsp_data_q, rsp_data_d;
	logic [7:0] rsp_exc_q, rsp_exc_d;
	mbw_tx_t tx_q, tx_d;
	logic [15:0] cur_q, cur_d;

	logic wd_expire;
	logic reply_expire;
	logic reply_running;
	logic [15:0] rd_hold;
	logic hold_hit;
	logic [15:0] rd_input;
	logic input_hit;
	logic [15:0] cur_scaled;

	mbw_cnt_if cnt1 ();
	mbw_cnt_if cnt2 ();

	////////////////////////////////////////////////////////////////////////
	// Counters
	mbw_pulse_counter #(.FILTER(FILTER)) u_cnt1 (
		.clk(clk),
		.reset(reset),
		.din(din_one),
		.bus(cnt1.cnt)
	);
	mbw_pulse_counter #(.FILTER(FILTER)) u_cnt2 (
		.clk(clk),
		.reset(reset),
		.din(din_two),
		.bus(cnt2.cnt)
	);

	////////////////////////////////////////////////////////////////////////
	// Timers
	mbw_ms_timer #(.MS_CYC(MS_CYC)) u_wdog (
		.clk(clk),
		.reset(reset),
		.start(msg_ok),
		.stop(wdog_q == 16'h0000),
		.load(wdog_q),
		.running(),
		.expire(wd_expire)
	);
	mbw_ms_timer #(.MS_CYC(MS_CYC)) u_reply (
		.clk(clk),
		.reset(reset),
		.start(msg_ok && tx_q == TX_IDLE),
		.stop(1'b0),
		.load(wait_q),
		.running(reply_running),
		.expire(reply_expire)
	);

	////////////////////////////////////////////////////////////////////////
	// Read decode
	always_comb
	begin
		hold_hit = 1'b1;
		unique case (req_addr)
			REG_LINE_SPEED: rd_hold = speed_q;
			REG_FRAME_BITS: rd_hold = frame_q;
			REG_PARITY: rd_hold = parity_q;
			REG_REPLY_WAIT: rd_hold = wait_q;
			REG_FRAMING: rd_hold = framing_q;
			REG_WATCHDOG: rd_hold = wdog_q;
			REG_DEFAULT_OUT: rd_hold = dflt_q;
			REG_OUTPUTS: rd_hold = outs_q;
			REG_AO_CURRENT: rd_hold = aoc_q;
			REG_AO_VOLTAGE: rd_hold = aov_q;
			REG_CNT1_LO: rd_hold = cnt1.count[15:0];
			REG_CNT1_HI: rd_hold = cnt1.count[31:16];
			REG_CNT2_LO: rd_hold = cnt2.count[15:0];
			REG_CNT2_HI: rd_hold = cnt2.count[31:16];
			REG_AO_MODE: rd_hold = aom_q;
			default:
			begin
				rd_hold = 16'h0000;
				hold_hit = 1'b0;
			end
		endcase
	end

	always_comb
	begin
		input_hit = 1'b1;
		unique case (req_addr)
			REG_VERSION: rd_input = VERSION_WORD;
			REG_SLAVE_ADDR: rd_input = SLAVE_ADDR_DEFAULT;
			REG_INPUTS: rd_input = {14'h0000, cnt2.level, cnt1.level};
			default:
			begin
				rd_input = 16'h0000;
				input_hit = 1'b0;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Register writes, answers and watchdog
	always_comb
	begin
		speed_d = speed_q;
		frame_d = frame_q;
		parity_d = parity_q;
		wait_d = wait_q;
		framing_d = framing_q;
		wdog_d = wdog_q;
		dflt_d = dflt_q;
		outs_d = outs_q;
		aoc_d = aoc_q;
		aov_d = aov_q;
		aom_d = aom_q;
		rsp_valid_d = req_valid;
		rsp_data_d = rsp_data_q;
		rsp_exc_d = EXC_NONE;
		cnt1.wr_lo = 1'b0;
		cnt1.wr_hi = 1'b0;
		cnt2.wr_lo = 1'b0;
		cnt2.wr_hi = 1'b0;
		cnt1.wdata = req_wdata;
		cnt2.wdata = req_wdata;
		// Timeout first so a write in the same cycle still lands
		if (wd_expire)
		begin
			outs_d = dflt_q;
			aoc_d = RST_ZERO;
			aov_d = RST_ZERO;
		end
		if (req_valid)
		begin
			rsp_data_d = 16'h0000;
			unique case (req_func)
				FC_RD_COILS:
					if (req_addr < COIL_COUNT)
						rsp_data_d = {15'h0000, outs_q[req_addr[3:0]]};
					else
						rsp_exc_d = EXC_ADDR;
				FC_RD_DISCRETE:
					if (req_addr < INPUT_COUNT)
						rsp_data_d = {15'h0000, req_addr[0] ? cnt2.level : cnt1.level};
					else
						rsp_exc_d = EXC_ADDR;
				FC_WR_COIL, FC_WR_COILS:
					if (req_addr >= COIL_COUNT)
						rsp_exc_d = EXC_ADDR;
					else if (req_func == FC_WR_COILS)
						outs_d[req_addr[3:0]] = req_wdata[0];
					else if (req_wdata == COIL_ON || req_wdata == 16'h0000)
						outs_d[req_addr[3:0]] = req_wdata[15];
					else
						rsp_exc_d = EXC_VALUE;
				FC_RD_INPUT_REG:
					if (input_hit)
						rsp_data_d = rd_input;
					else
						rsp_exc_d = EXC_ADDR;
				FC_RD_HOLD_REG:
					if (hold_hit)
						rsp_data_d = rd_hold;
					else
						rsp_exc_d = EXC_ADDR;
				FC_WR_HOLD_REG, FC_WR_HOLD_REGS:
					if (!hold_hit)
						rsp_exc_d = EXC_ADDR;
					else
					begin
						unique case (req_addr)
							REG_LINE_SPEED: speed_d = req_wdata;
							REG_FRAME_BITS: frame_d = req_wdata;
							REG_PARITY: parity_d = req_wdata;
							REG_REPLY_WAIT: wait_d = req_wdata;
							REG_FRAMING: framing_d = req_wdata;
							REG_WATCHDOG: wdog_d = req_wdata;
							REG_DEFAULT_OUT: dflt_d = req_wdata;
							REG_OUTPUTS: outs_d = req_wdata;
							REG_AO_CURRENT: aoc_d = req_wdata;
							REG_AO_VOLTAGE: aov_d = req_wdata;
							REG_CNT1_LO: cnt1.wr_lo = 1'b1;
							REG_CNT1_HI: cnt1.wr_hi = 1'b1;
							REG_CNT2_LO: cnt2.wr_lo = 1'b1;
							REG_CNT2_HI: cnt2.wr_hi = 1'b1;
							default: aom_d = req_wdata;
						endcase
					end
				default: rsp_exc_d = EXC_FUNC;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Reply sequencing
	always_comb
	begin
		tx_d = tx_q;
		unique case (tx_q)
			TX_IDLE:
				// Zero delay never starts the timer, so go straight to sending
				if (msg_ok)
					tx_d = (wait_q == 16'h0000) ? TX_SEND : TX_WAIT;
			TX_WAIT:
				if (reply_expire)
					tx_d = TX_SEND;
			TX_SEND:
				if (tx_done)
					tx_d = TX_IDLE;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Current output scaling
	// Live-zero mode spans 16000 uA over 1000 steps
	assign cur_scaled = 16'(LIVE_ZERO_UA + 16'(aoc_q * STEP_UA));
	always_comb
	begin
		cur_d = aom_q[0] ? cur_scaled : aoc_q;
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			speed_q <= RST_LINE_SPEED;
			frame_q <= RST_FRAME_BITS;
			parity_q <= RST_ZERO;
			wait_q <= RST_ZERO;
			framing_q <= RST_ZERO;
			wdog_q <= RST_ZERO;
			dflt_q <= RST_ZERO;
			outs_q <= RST_ZERO;
			aoc_q <= RST_ZERO;
			aov_q <= RST_ZERO;
			aom_q <= RST_ZERO;
			rsp_valid_q <= 1'b0;
			rsp_data_q <= 16'h0000;
			rsp_exc_q <= EXC_NONE;
			tx_q <= TX_IDLE;
			cur_q <= 16'h0000;
		end
		else
		begin
			speed_q <= speed_d;
			frame_q <= frame_d;
			parity_q <= parity_d;
			wait_q <= wait_d;
			framing_q <= framing_d;
			wdog_q <= wdog_d;
			dflt_q <= dflt_d;
			outs_q <= outs_d;
			aoc_q <= aoc_d;
			aov_q <= aov_d;
			aom_q <= aom_d;
			rsp_valid_q <= rsp_valid_d;
			rsp_data_q <= rsp_data_d;
			rsp_exc_q <= rsp_exc_d;
			tx_q <= tx_d;
			cur_q <= cur_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs
	assign rsp_valid = rsp_valid_q;
	assign rsp_data = rsp_data_q;
	assign rsp_exc = rsp_exc_q;
	assign tx_start = (tx_q != TX_SEND) && (tx_d == TX_SEND);
	assign slave_address = SLAVE_ADDR_DEFAULT[7:0];
	assign line_speed_bps = mbw_baud(speed_q);
	// Codes above four are kept but read as no parity
	assign parity_mode = (parity_q > 16'h0004) ? PAR_NONE : mbw_parity_t'(parity_q[2:0]);
	assign two_stop_bits = (frame_q[15:8] == STOP_TWO);
	assign seven_data_bits = (frame_q[7:0] == DATA_SEVEN);
	assign ascii_framing = framing_q[0];
	assign dig_out = outs_q;
	assign ao_4_20_mode = aom_q[0];
	assign ao_current_ua = cur_q;
	assign ao_voltage_mv = aov_q;
	assign input_one_indicator = cnt1.level;
	assign input_two_indicator = cnt2.level;
	assign tx_indicator = (tx_q != TX_IDLE);
endmodule
